// *** cnmc_device.sv ***
// CAN node end: controller mode sequencing plus transceiver mode.
// Assumes the host end on the link and a protocol engine on the
// user side; the bus pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module cnmc_device
  import cnmc_pkg::*;
#(
  parameter int FILT_CYC = WAKE_FILT_CYC,
  parameter int OST_CYC  = OST_CYCLES
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // Host link
  cnmc_link_if.dev         LNK,
  // Protocol engine side
  input  wire logic        ENG_TX_BIT,
  input  wire logic        ENG_TX_PEND,
  output logic             ENG_TX_START_OK,
  output logic             ENG_ACK_EN,
  output logic             ENG_RX_BIT,
  output logic             ENG_RX_ALL,
  output logic             ENG_RX_DISCARD,
  output logic             ERR_CLR,
  output logic             OSC_RUN,
  // Protected configuration contents
  output logic [7:0]       CFG_BT1,
  output logic [7:0]       CFG_BT2,
  output logic [7:0]       CFG_BT3,
  output logic [7:0]       CFG_RTS,
  output logic [31:0]      CFG_FILT,
  // CAN bus, open-drain style
  input  wire logic        BUS_RX_I,
  output logic             BUS_TX_O,
  output logic             BUS_TX_OE
);

  typedef struct packed {
    logic [2:0]  op;
    logic [2:0]  req;
    logic        waking;
    logic [7:0]  ost;
    logic [2:0]  bsync;
    logic        bus;
    logic        xrxd;
    logic        xrxd_prev;
    logic        ctrl_tx;
    logic        eng_rx;
    logic        bus_oe;
    logic        tx_ok;
    logic        ack_en;
    logic        rx_all;
    logic        discard;
    logic        err_clr;
    logic        osc_run;
    logic [7:0]  bt1;
    logic [7:0]  bt2;
    logic [7:0]  bt3;
    logic [7:0]  rts;
    logic [31:0] filt;
  } cnmc_dev_t;

  localparam cnmc_dev_t DEV_RST = '{
    op:        MODE_CONFIG,
    req:       MODE_CONFIG,
    bsync:     {3{RECESSIVE}},
    bus:       RECESSIVE,
    xrxd:      RECESSIVE,
    xrxd_prev: RECESSIVE,
    ctrl_tx:   RECESSIVE,
    eng_rx:    RECESSIVE,
    err_clr:   1'b1,
    osc_run:   1'b1,
    bt1:       CFG_RST,
    bt2:       CFG_RST,
    bt3:       CFG_RST,
    rts:       CFG_RST,
    filt:      {FILT_BYTES{CFG_RST}},
    default:   '0
  };

  cnmc_dev_t q;
  cnmc_dev_t d;
  logic      filt_out;

  // Standby receive path sees the bus only through this filter
  cnmc_wake_filter #(
    .N (FILT_CYC)
  ) u_wake_filt (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .lvl_in  (q.bus),
    .lvl_out (filt_out)
  );

  always_comb begin
    d = q;
    d.err_clr = 1'b0;

    // Bus pin: first stage feeds only the second
    d.bsync = {q.bsync[1:0], BUS_RX_I};
    if (q.bsync[1] == q.bsync[2]) begin
      d.bus = q.bsync[2];
    end

    // Unknown codes are dropped so the request never names a
    // mode the sequencer cannot reach
    if (LNK.req_wr && mode_valid(LNK.req_mode)) begin
      d.req = LNK.req_mode;
    end

    if (q.waking) begin
      // Wake completes after oscillator start-up; host requests
      // made meanwhile are overridden by listen-only
      if (q.ost == 8'(OST_CYC - 1)) begin
        d.waking  = 1'b0;
        d.op      = MODE_LISTEN;
        d.req     = MODE_LISTEN;
        d.discard = 1'b0;
      end else begin
        d.ost = q.ost + 8'h01;
      end
    end else if (q.op == MODE_SLEEP && q.xrxd_prev && !q.xrxd) begin
      // Falling edge on the receive input is bus activity
      d.waking  = 1'b1;
      d.ost     = 8'h00;
      d.discard = 1'b1;
    end else if (q.req != q.op && !ENG_TX_PEND) begin
      d.op = q.req;
      if (q.req == MODE_CONFIG) begin
        d.err_clr = 1'b1;
      end
    end

    // Oscillator runs except in settled sleep
    d.osc_run = (d.op != MODE_SLEEP) || d.waking;

    // Protected registers change only in configuration
    if (LNK.cfg_wr && q.op == MODE_CONFIG) begin
      case (LNK.cfg_sel)
        CFG_SEL_BT1: d.bt1 = LNK.cfg_data;
        CFG_SEL_BT2: d.bt2 = LNK.cfg_data;
        CFG_SEL_BT3: d.bt3 = LNK.cfg_data;
        CFG_SEL_RTS: d.rts = LNK.cfg_data;
        default: begin
          if (LNK.cfg_sel >= CFG_SEL_FILT) begin
            d.filt[8 * (LNK.cfg_sel - CFG_SEL_FILT) +: 8] = LNK.cfg_data;
          end
        end
      endcase
    end

    // Controller side of the link to the transceiver
    d.tx_ok   = q.op == MODE_NORMAL;
    d.ack_en  = q.op == MODE_NORMAL;
    d.rx_all  = q.op == MODE_LISTEN;
    d.ctrl_tx = (q.op == MODE_NORMAL) ? ENG_TX_BIT : RECESSIVE;
    d.eng_rx  = (q.op == MODE_LOOP) ? ENG_TX_BIT : q.xrxd;

    // Transceiver: driver only when standby pin is low
    d.bus_oe    = !LNK.standby_select_pin && (q.ctrl_tx != RECESSIVE);
    d.xrxd      = LNK.standby_select_pin ? filt_out : q.bus;
    d.xrxd_prev = q.xrxd;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  assign LNK.op_mode     = q.op;
  assign ENG_TX_START_OK = q.tx_ok;
  assign ENG_ACK_EN      = q.ack_en;
  assign ENG_RX_BIT      = q.eng_rx;
  assign ENG_RX_ALL      = q.rx_all;
  assign ENG_RX_DISCARD  = q.discard;
  assign ERR_CLR         = q.err_clr;
  assign OSC_RUN         = q.osc_run;
  assign CFG_BT1         = q.bt1;
  assign CFG_BT2         = q.bt2;
  assign CFG_BT3         = q.bt3;
  assign CFG_RTS         = q.rts;
  assign CFG_FILT        = q.filt;
  assign BUS_TX_O        = 1'b0;
  assign BUS_TX_OE       = q.bus_oe;

endmodule : cnmc_device
`default_nettype wire

// *** cnmc_pkg.sv ***
// Shared constants for the CAN node mode control pair.
// Assumes both ends run on one 50 MHz clock.
package cnmc_pkg;

  // Operating and requested mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SLEEP  = 3'h1;
  localparam logic [2:0] MODE_LOOP   = 3'h2;
  localparam logic [2:0] MODE_LISTEN = 3'h3;
  localparam logic [2:0] MODE_CONFIG = 3'h4;

  // Configuration-protected register select codes
  localparam logic [2:0] CFG_SEL_BT1  = 3'h0;
  localparam logic [2:0] CFG_SEL_BT2  = 3'h1;
  localparam logic [2:0] CFG_SEL_BT3  = 3'h2;
  localparam logic [2:0] CFG_SEL_RTS  = 3'h3;
  localparam logic [2:0] CFG_SEL_FILT = 3'h4;
  localparam int         FILT_BYTES   = 4;
  localparam logic [7:0] CFG_RST      = 8'h00;

  // Bus levels
  localparam logic RECESSIVE = 1'b1;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int WAKE_FILT_NS  = 500;
  localparam int WAKE_FILT_CYC =
    (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OST_CYCLES    = 128;

  function automatic logic mode_valid(input logic [2:0] m);
    return m <= MODE_CONFIG;
  endfunction : mode_valid

endpackage : cnmc_pkg

// *** cnmc_link_if.sv ***
// Link between host and CAN node: mode request, status, standby pin,
// configuration writes. Both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cnmc_link_if;
  logic       req_wr;
  logic [2:0] req_mode;
  logic [2:0] op_mode;
  logic       standby_select_pin;
  logic       cfg_wr;
  logic [2:0] cfg_sel;
  logic [7:0] cfg_data;

  modport dev (
    input  req_wr, req_mode, standby_select_pin, cfg_wr, cfg_sel, cfg_data,
    output op_mode
  );
  modport host (
    output req_wr, req_mode, standby_select_pin, cfg_wr, cfg_sel, cfg_data,
    input  op_mode
  );
endinterface : cnmc_link_if
`default_nettype wire

// *** cnmc_wake_filter.sv ***
// Wake-up filter: passes a bus level only once it held for N cycles.
// Assumes a synchronised input on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cnmc_wake_filter #(
  parameter int N = 25
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level
  input  wire logic lvl_in,
  output logic      lvl_out
);
  // Idle bus level; declared before the reset value that uses it
  localparam logic RECESSIVE_L = 1'b1;

  typedef struct packed {
    logic       out;
    logic [15:0] cnt;
  } cnmc_filt_t;

  cnmc_filt_t q;
  cnmc_filt_t d;

  always_comb begin
    d = q;
    if (lvl_in == q.out) begin
      d.cnt = '0;
    end else if (q.cnt == 16'(N - 1)) begin
      // Short glitches never reach the output, hence the delay
      d.out = lvl_in;
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{out: RECESSIVE_L, cnt: 16'h0000};
    end else begin
      q <= d;
    end
  end

  assign lvl_out = q.out;
endmodule : cnmc_wake_filter
`default_nettype wire

// *** cnmc_host.sv ***
// Host end: issues mode requests, drives the standby pin, performs
// protected configuration writes and confirms the reported mode.
// Assumes the node end on the link, same clock.
`timescale 1ns/1ps
`default_nettype none
module cnmc_host
  import cnmc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // Node link
  cnmc_link_if.host        LNK,
  // Mode requests
  input  wire logic        USR_MODE_WR,
  input  wire logic [2:0]  USR_MODE,
  output logic             USR_MODE_DONE,
  output logic [2:0]       USR_OP_MODE,
  // Configuration writes
  input  wire logic        USR_CFG_WR,
  input  wire logic [2:0]  USR_CFG_SEL,
  input  wire logic [7:0]  USR_CFG_DATA,
  output logic             USR_CFG_ERR,
  // Transceiver mode
  input  wire logic        USR_STANDBY_SELECT_PIN,
  output logic             USR_BUS_READY
);

  typedef struct packed {
    logic       standby_select_pin;
    logic       req_wr;
    logic [2:0] req_mode;
    logic       cfg_wr;
    logic [2:0] cfg_sel;
    logic [7:0] cfg_data;
    logic [2:0] pend;
    logic       done;
    logic [2:0] op_seen;
    logic       cfg_err;
    logic       bus_ready;
  } cnmc_host_t;

  localparam cnmc_host_t HOST_RST = '{
    standby_select_pin:     1'b1,
    req_mode: MODE_CONFIG,
    pend:     MODE_CONFIG,
    op_seen:  MODE_CONFIG,
    default:  '0
  };

  cnmc_host_t q;
  cnmc_host_t d;

  always_comb begin
    d = q;
    d.req_wr = 1'b0;
    d.cfg_wr = 1'b0;
    d.cfg_err = 1'b0;
    d.standby_select_pin = USR_STANDBY_SELECT_PIN;

    if (USR_MODE_WR && mode_valid(USR_MODE)) begin
      d.req_wr   = 1'b1;
      d.req_mode = USR_MODE;
      d.pend     = USR_MODE;
    end

    // Writes outside configuration would be lost, so refuse them
    if (USR_CFG_WR) begin
      if (LNK.op_mode == MODE_CONFIG) begin
        d.cfg_wr   = 1'b1;
        d.cfg_sel  = USR_CFG_SEL;
        d.cfg_data = USR_CFG_DATA;
      end else begin
        d.cfg_err = 1'b1;
      end
    end

    // Done only when the node reports the mode, not on request
    d.done      = (LNK.op_mode == d.pend) && !d.req_wr;
    d.op_seen   = LNK.op_mode;
    d.bus_ready = (LNK.op_mode == MODE_NORMAL) && !q.standby_select_pin;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  assign LNK.standby_select_pin      = q.standby_select_pin;
  assign LNK.req_wr    = q.req_wr;
  assign LNK.req_mode  = q.req_mode;
  assign LNK.cfg_wr    = q.cfg_wr;
  assign LNK.cfg_sel   = q.cfg_sel;
  assign LNK.cfg_data  = q.cfg_data;
  assign USR_MODE_DONE = q.done;
  assign USR_OP_MODE   = q.op_seen;
  assign USR_CFG_ERR   = q.cfg_err;
  assign USR_BUS_READY = q.bus_ready;

endmodule : cnmc_host
`default_nettype wire

// *** cnmc_link_chk.sv ***
// Checker for the host to node mode link.
// Assumes one clock; placed beside the link interface in the bench.
`timescale 1ns/1ps
`default_nettype none
module cnmc_link_chk
  import cnmc_pkg::*;
(
  // Clock and reset
  input wire logic       CLOCK,
  input wire logic       SYS_RST,
  // Link
  input wire logic       req_wr,
  input wire logic [2:0] req_mode,
  input wire logic [2:0] op_mode,
  input wire logic       standby_select_pin,
  input wire logic       cfg_wr
);
  logic [2:0] last_q;
  // Last accepted request; a change of mode out of any mode but sleep must land on it
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) last_q <= MODE_CONFIG;
    else if (req_wr) last_q <= req_mode;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_left_sleep;
    $past(op_mode) == MODE_SLEEP && op_mode != MODE_SLEEP;
  endsequence
  sequence s_settled;
    op_mode == last_q && op_mode != MODE_SLEEP && !req_wr;
  endsequence
  property p_rst_cfg; $fell(SYS_RST) |-> op_mode == MODE_CONFIG; endproperty
  property p_rst_quiet; $fell(SYS_RST) |-> standby_select_pin && !req_wr && !cfg_wr; endproperty
  property p_op_valid; op_mode <= MODE_CONFIG; endproperty
  property p_req_valid; req_wr |-> req_mode <= MODE_CONFIG; endproperty
  property p_op_follows;
    $changed(op_mode) && $past(op_mode) != MODE_SLEEP
      |-> op_mode == last_q || op_mode == $past(last_q);
  endproperty
  property p_wake_listen; s_left_sleep |-> op_mode == MODE_LISTEN; endproperty
  property p_op_holds; s_settled [*2] |=> $stable(op_mode); endproperty
  property p_cfg_gate; cfg_wr |-> $past(op_mode) == MODE_CONFIG; endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("not config after reset");
  a_rst_quiet: assert property (p_rst_quiet) else $error("link busy after reset");
  a_op_valid: assert property (p_op_valid) else $error("bad mode code");
  a_req_valid: assert property (p_req_valid) else $error("bad request code");
  a_op_follows: assert property (p_op_follows) else $error("unrequested mode");
  a_wake_listen: assert property (p_wake_listen) else $error("wake not listen");
  a_op_holds: assert property (p_op_holds) else $error("mode moved idle");
  a_cfg_gate: assert property (p_cfg_gate) else $error("write outside config");
endmodule : cnmc_link_chk
`default_nettype wire

// *** cnmc_tb_top.sv ***
// Bench joining host and node ends over the link interface.
// Assumes short wake filter and start-up counts set below.
`timescale 1ns/1ps
`default_nettype none
module cnmc_tb_top
  import cnmc_pkg::*;
;
  localparam int FC = 4;
  localparam int OC = 8;
  logic        clk = 0, rst = 1, mwr = 0, cwr = 0, ustby = 1;
  logic        tbit = 1, tpend = 0, brx = 1, n;
  logic [2:0]  umode = 0, csel = 0, uop;
  logic [7:0]  cdata = 0, bt1, bt2, bt3, rts;
  logic [31:0] filt;
  logic [63:0] exp_cfg = 0;
  logic        done, cerr, bready, sok, acken, rxb, rxall, disc, eclr, osc, txo, txoe;
  logic [2:0]  seq [4] = '{MODE_NORMAL, MODE_LOOP, MODE_LISTEN, MODE_CONFIG};
  int          num_errors = 0, checks_done = 0, clr_cnt = 0, c0;
  // Open-drain bus: the node pulls it dominant, the bench may too
  wire         bus = brx & ~txoe;
  cnmc_link_if lnk ();
  cnmc_device #(.FILT_CYC(FC), .OST_CYC(OC)) cnmc_device_i (.CLOCK(clk), .SYS_RST(rst),
    .LNK(lnk), .ENG_TX_BIT(tbit), .ENG_TX_PEND(tpend), .ENG_TX_START_OK(sok),
    .ENG_ACK_EN(acken), .ENG_RX_BIT(rxb), .ENG_RX_ALL(rxall), .ENG_RX_DISCARD(disc),
    .ERR_CLR(eclr), .OSC_RUN(osc), .CFG_BT1(bt1), .CFG_BT2(bt2), .CFG_BT3(bt3),
    .CFG_RTS(rts), .CFG_FILT(filt), .BUS_RX_I(bus), .BUS_TX_O(txo), .BUS_TX_OE(txoe));
  cnmc_host cnmc_host_i (.CLOCK(clk), .SYS_RST(rst), .LNK(lnk), .USR_MODE_WR(mwr),
    .USR_MODE(umode), .USR_MODE_DONE(done), .USR_OP_MODE(uop), .USR_CFG_WR(cwr),
    .USR_CFG_SEL(csel), .USR_CFG_DATA(cdata), .USR_CFG_ERR(cerr), .USR_STANDBY_SELECT_PIN(ustby),
    .USR_BUS_READY(bready));
  cnmc_link_chk cnmc_link_chk_i (.CLOCK(clk), .SYS_RST(rst), .req_wr(lnk.req_wr),
    .req_mode(lnk.req_mode), .op_mode(lnk.op_mode), .standby_select_pin(lnk.standby_select_pin), .cfg_wr(lnk.cfg_wr));
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (eclr === 1'b1) clr_cnt++;
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : tick
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // Bit position of a select code in the packed expectation
  function automatic int top_bit(input int s);
    return (s < 4) ? 63 - 8 * s : 8 * s - 25;
  endfunction : top_bit
  task automatic cfg_write(input int s, input logic [7:0] d, input logic ok);
    cwr = 1; csel = s[2:0]; cdata = d; tick(1);
    cwr = 0;
    // The refusal pulse stands for this one cycle only
    chk(cerr, !ok);
    if (ok) exp_cfg[top_bit(s) -: 8] = d;
    tick(1);
    chk({bt1, bt2, bt3, rts, filt}, exp_cfg);
  endtask : cfg_write
  task automatic set_mode(input logic [2:0] md, input int pend_cyc);
    mwr = 1; umode = md; tick(1);
    mwr = 0; tick(pend_cyc);
    chk(uop === md, !tpend);
    chk(done, !tpend);
    tpend = 0;
    for (int i = 0; i < 40 && done !== 1'b1; i++) tick(1);
    tick(2);
    chk(uop, md);
    chk(done, 1'b1);
  endtask : set_mode
  initial begin
    c0 = $urandom(32'h7116);
    tick(20); rst = 0; tick(2);
    chk({uop, osc, txoe, txo, bt1, filt}, {MODE_CONFIG, 1'b1, 1'b0, 1'b0, 8'h00, 32'h0});
    // Codes above configuration must be dropped without a request
    mwr = 1; umode = 3'(3'h5 + $urandom_range(2)); tick(1);
    mwr = 0; tick(4);
    chk({uop, done}, {MODE_CONFIG, 1'b1});
    for (int s = 0; s < 8; s++) cfg_write(s, 8'($urandom), 1'b1);
    ustby = 0;
    foreach (seq[k]) begin
      n = seq[k] == MODE_NORMAL;
      set_mode(seq[k], 4);
      chk({sok, acken, rxall, bready}, {n, n, seq[k] == MODE_LISTEN, n});
      // Dominant needs two stages out, the four-stage pin path and two stages to come back
      tbit = 0; tick(10);
      chk({txoe, rxb}, {n, !(n || seq[k] == MODE_LOOP)});
      tbit = 1; tick(4);
      cfg_write($urandom_range(7), 8'($urandom), seq[k] == MODE_CONFIG);
    end
    tpend = 1;
    set_mode(MODE_NORMAL, 12);
    c0 = clr_cnt;
    set_mode(MODE_CONFIG, 4);
    chk(clr_cnt, c0 + 1);
    set_mode(MODE_NORMAL, 4);
    ustby = 1; tbit = 0; tick(4);
    chk(txoe, 1'b0);
    tbit = 1; brx = 0; tick(FC - 2);
    // Looked at while an unfiltered glitch would still show as dominant
    brx = 1; tick(4);
    chk(rxb, 1'b1);
    tick(4);
    set_mode(MODE_SLEEP, 4);
    tick(4);
    chk(osc, 1'b0);
    brx = 0; tick(FC + 6);
    chk(disc, 1'b1);
    tick(OC + 4);
    brx = 1;
    chk({uop, disc, osc}, {MODE_LISTEN, 1'b0, 1'b1});
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule : cnmc_tb_top
`default_nettype wire
